// File: core/scan_params.svh
// Constants for the boundary-scan data registers and instruction codes
`ifndef SCAN_PARAMS_SVH
`define SCAN_PARAMS_SVH

// ----------------------------------------------------------------
// Instruction register
// ----------------------------------------------------------------
`define IR_W 3
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE_HIZ 3'h2
`define IR_SAMPLE 3'h4
`define IR_BYPASS 3'h7
`define IR_CAPTURE_VAL 3'h1

// ----------------------------------------------------------------
// Data register lengths and fields
// ----------------------------------------------------------------
`define ID_LEN 32
`define ID_DEV_W 20
`define ID_MFR_W 11
`define ID_START_VAL 1'h1
`define BSR_LEN 129
`define PAD_CNT 128

// ----------------------------------------------------------------
// Chain indices (index = chain position - 1)
// ----------------------------------------------------------------
`define POS_DRV_EN 128
`define POS_Q_LO 0
`define POS_VLD 36
`define POS_ECHO 37
`define POS_ECHO_N 38
`define DRV_EN_CAPTURE 1'h1
`define NC_CAPTURE 1'h0
`define BYPASS_CAPTURE 1'h0

`endif

// File: core/scan_pkg.sv
// Types shared by the test access port logic
package scan_pkg;

  // Sixteen controller states of the test access port
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_e;

  typedef logic [2:0] instr_t;

endpackage

// File: core/pin_sync.sv
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else if (i_ce)
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// File: core/tap_ctrl.sv
// Sixteen-state test access port controller stepped by sampled clock edges
`timescale 1ns/1ps
module tap_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_step,
  input wire logic i_tms,
  output scan_pkg::tap_state_e o_state
);

  scan_pkg::tap_state_e next_state;

  // Standard transition table, mode select sampled on the rising test clock
  always_comb
  begin
    case (o_state)
      scan_pkg::TEST_LOGIC_RESET: next_state = i_tms ? scan_pkg::TEST_LOGIC_RESET : scan_pkg::RUN_TEST_IDLE;
      scan_pkg::RUN_TEST_IDLE: next_state = i_tms ? scan_pkg::SELECT_DR : scan_pkg::RUN_TEST_IDLE;
      scan_pkg::SELECT_DR: next_state = i_tms ? scan_pkg::SELECT_IR : scan_pkg::CAPTURE_DR;
      scan_pkg::CAPTURE_DR: next_state = i_tms ? scan_pkg::EXIT1_DR : scan_pkg::SHIFT_DR;
      scan_pkg::SHIFT_DR: next_state = i_tms ? scan_pkg::EXIT1_DR : scan_pkg::SHIFT_DR;
      scan_pkg::EXIT1_DR: next_state = i_tms ? scan_pkg::UPDATE_DR : scan_pkg::PAUSE_DR;
      scan_pkg::PAUSE_DR: next_state = i_tms ? scan_pkg::EXIT2_DR : scan_pkg::PAUSE_DR;
      scan_pkg::EXIT2_DR: next_state = i_tms ? scan_pkg::UPDATE_DR : scan_pkg::SHIFT_DR;
      scan_pkg::UPDATE_DR: next_state = i_tms ? scan_pkg::SELECT_DR : scan_pkg::RUN_TEST_IDLE;
      scan_pkg::SELECT_IR: next_state = i_tms ? scan_pkg::TEST_LOGIC_RESET : scan_pkg::CAPTURE_IR;
      scan_pkg::CAPTURE_IR: next_state = i_tms ? scan_pkg::EXIT1_IR : scan_pkg::SHIFT_IR;
      scan_pkg::SHIFT_IR: next_state = i_tms ? scan_pkg::EXIT1_IR : scan_pkg::SHIFT_IR;
      scan_pkg::EXIT1_IR: next_state = i_tms ? scan_pkg::UPDATE_IR : scan_pkg::PAUSE_IR;
      scan_pkg::PAUSE_IR: next_state = i_tms ? scan_pkg::EXIT2_IR : scan_pkg::PAUSE_IR;
      scan_pkg::EXIT2_IR: next_state = i_tms ? scan_pkg::UPDATE_IR : scan_pkg::SHIFT_IR;
      scan_pkg::UPDATE_IR: next_state = i_tms ? scan_pkg::SELECT_DR : scan_pkg::RUN_TEST_IDLE;
      default: next_state = scan_pkg::TEST_LOGIC_RESET;
    endcase
  end

  // State advances only on a detected rising test clock edge
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_state <= scan_pkg::TEST_LOGIC_RESET;
    else if (i_ce && i_step)
      o_state <= next_state;
  end

endmodule

// File: core/scan_dr_top.sv
// Boundary-scan test data registers with instruction decode and pin control
`timescale 1ns/1ps
`include "scan_params.svh"
module scan_dr_top #(
  parameter int Q_W = 36,
  parameter logic [`ID_DEV_W-1:0] DEV_ID = 20'h00000, // Arbitrary value
  parameter logic [`ID_MFR_W-1:0] MFR_ID = 11'h000, // Arbitrary value
  parameter logic [`PAD_CNT-1:0] NC_MASK = 128'h0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  input wire logic [`PAD_CNT-1:0] i_pad_level,
  input wire logic [Q_W-1:0] i_func_q,
  input wire logic i_func_q_oe,
  input wire logic i_func_vld,
  input wire logic i_func_echo,
  input wire logic i_func_echo_n,
  input wire logic i_func_term_en,
  output logic [Q_W-1:0] o_q,
  output logic o_q_oe,
  output logic o_vld,
  output logic o_echo,
  output logic o_echo_n,
  output logic o_term_en
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Instructions that select the boundary chain
  function automatic logic is_boundary(input scan_pkg::instr_t ir);
    is_boundary = (ir == `IR_EXTEST) || (ir == `IR_SAMPLE) || (ir == `IR_SAMPLE_HIZ);
  endfunction

  // Reserved codes fall back to the bypass stage so the path stays defined
  function automatic logic is_bypass(input scan_pkg::instr_t ir);
    is_bypass = !is_boundary(ir) && (ir != `IR_IDCODE);
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers and test clock edge detect
  // ----------------------------------------------------------------

  logic [2:0] tap_sync;
  logic [`PAD_CNT-1:0] pad_sync;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_prev;
  logic tck_rise;
  logic tck_fall;

  // Test pins come from another domain: two flops before use
  pin_sync #(
    .W(3)
  ) u_tap_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async({i_tck, i_tms, i_tdi}),
    .o_sync(tap_sync)
  );

  // Pad levels are synchronised as well; capture sees a settled copy
  pin_sync #(
    .W(`PAD_CNT)
  ) u_pad_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_async(i_pad_level),
    .o_sync(pad_sync)
  );

  assign tck_s = tap_sync[2];
  assign tms_s = tap_sync[1];
  assign tdi_s = tap_sync[0];

  // Previous test clock level for edge detection
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      tck_prev <= 1'b0;
    else if (i_ce)
      tck_prev <= tck_s;
  end

  // TMS and TDI share the same sync delay, so they are sampled with the edge
  assign tck_rise = i_ce && tck_s && !tck_prev;
  assign tck_fall = i_ce && !tck_s && tck_prev;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------

  scan_pkg::tap_state_e state;

  tap_ctrl u_tap_ctrl (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_step(tck_rise),
    .i_tms(tms_s),
    .o_state(state)
  );

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------

  scan_pkg::instr_t ir_shift;
  scan_pkg::instr_t ir_active;

  // Shift stage: captures the fixed pattern, shifts toward bit 0
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ir_shift <= `IR_IDCODE;
    else if (tck_rise)
    begin
      if (state == scan_pkg::CAPTURE_IR)
        ir_shift <= `IR_CAPTURE_VAL;
      else if (state == scan_pkg::SHIFT_IR)
        ir_shift <= {tdi_s, ir_shift[`IR_W-1:1]};
    end
  end

  // Active instruction changes only at Update-IR; reset and the Test-Logic-Reset state force identification
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ir_active <= `IR_IDCODE;
    else if (i_ce && state == scan_pkg::TEST_LOGIC_RESET)
      ir_active <= `IR_IDCODE;
    else if (tck_fall && state == scan_pkg::UPDATE_IR)
      ir_active <= ir_shift;
  end

  logic sel_boundary;
  logic sel_bypass;
  logic sel_id;
  logic mode_extest;
  logic mode_hiz;

  assign sel_boundary = is_boundary(ir_active);
  assign sel_bypass = is_bypass(ir_active);
  assign sel_id = (ir_active == `IR_IDCODE);
  assign mode_extest = (ir_active == `IR_EXTEST);
  assign mode_hiz = (ir_active == `IR_SAMPLE_HIZ);

  // ----------------------------------------------------------------
  // Test data registers
  // ----------------------------------------------------------------

  logic single_bit_shift_path;
  logic [`ID_LEN-1:0] part_code_shift_reg;
  logic [`BSR_LEN-1:0] pin_state_scan_chain;
  logic [`BSR_LEN-1:0] pin_hold;
  logic cap_dr;
  logic shf_dr;

  assign cap_dr = tck_rise && (state == scan_pkg::CAPTURE_DR);
  assign shf_dr = tck_rise && (state == scan_pkg::SHIFT_DR);

  // One-stage bypass path
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      single_bit_shift_path <= `BYPASS_CAPTURE;
    else if (sel_bypass)
    begin
      if (cap_dr)
        single_bit_shift_path <= `BYPASS_CAPTURE;
      else if (shf_dr)
        single_bit_shift_path <= tdi_s;
    end
  end

  // Identification register: code, maker, start bit
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      part_code_shift_reg <= '0;
    else if (sel_id)
    begin
      if (cap_dr)
        part_code_shift_reg <= {DEV_ID, MFR_ID, `ID_START_VAL};
      else if (shf_dr)
        part_code_shift_reg <= {tdi_s, part_code_shift_reg[`ID_LEN-1:1]};
    end
  end

  // Boundary chain: index 0 is position 1; pads occupy 1..128, 129 is internal
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pin_state_scan_chain <= '0;
    else if (sel_boundary)
    begin
      if (cap_dr)
        pin_state_scan_chain <= {`DRV_EN_CAPTURE, pad_sync & ~NC_MASK};
      else if (shf_dr)
        pin_state_scan_chain <= {tdi_s, pin_state_scan_chain[`BSR_LEN-1:1]};
    end
  end

  // Update stage keeps shifting invisible at the pins until Update-DR
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pin_hold <= '0;
    else if (tck_fall && sel_boundary && state == scan_pkg::UPDATE_DR)
      pin_hold <= pin_state_scan_chain;
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------

  logic next_tdo;

  // Least significant stage of the selected register leaves first
  always_comb
  begin
    if (state == scan_pkg::SHIFT_IR)
      next_tdo = ir_shift[0];
    else if (sel_boundary)
      next_tdo = pin_state_scan_chain[0];
    else if (sel_id)
      next_tdo = part_code_shift_reg[0];
    else
      next_tdo = single_bit_shift_path;
  end

  // Data out and its enable change on the falling test clock
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      o_tdo <= next_tdo;
      o_tdo_oe <= (state == scan_pkg::SHIFT_DR) || (state == scan_pkg::SHIFT_IR);
    end
  end

  // ----------------------------------------------------------------
  // Pin control
  // ----------------------------------------------------------------

  logic [Q_W-1:0] next_q;
  logic next_q_oe;
  logic next_vld;
  logic next_echo;
  logic next_echo_n;
  logic next_term_en;

  // Chain owns the outputs except termination enable, and only under external test
  always_comb
  begin
    if (mode_extest)
    begin
      next_q = pin_hold[`POS_Q_LO +: Q_W];
      next_q_oe = pin_hold[`POS_DRV_EN];
      next_vld = pin_hold[`POS_VLD];
      next_echo = pin_hold[`POS_ECHO];
      next_echo_n = pin_hold[`POS_ECHO_N];
    end
    else
    begin
      next_q = i_func_q;
      next_q_oe = i_func_q_oe && !mode_hiz;
      next_vld = i_func_vld;
      next_echo = i_func_echo;
      next_echo_n = i_func_echo_n;
    end
    next_term_en = i_func_term_en && !mode_extest && !mode_hiz;
  end

  // Registered pin drive, one clock after the control changes
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_q <= '0;
      o_q_oe <= 1'b0;
      o_vld <= 1'b0;
      o_echo <= 1'b0;
      o_echo_n <= 1'b0;
      o_term_en <= 1'b0;
    end
    else if (i_ce)
    begin
      o_q <= next_q;
      o_q_oe <= next_q_oe;
      o_vld <= next_vld;
      o_echo <= next_echo;
      o_echo_n <= next_echo_n;
      o_term_en <= next_term_en;
    end
  end

endmodule

// File: tb/scan_dr_checker.sv
// Concurrent checks on the scan data register top ports
`timescale 1ns/1ps
module scan_dr_checker #(
  parameter int Q_W = 36
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tck,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic [Q_W-1:0] i_func_q,
  input wire logic i_func_q_oe,
  input wire logic i_func_vld,
  input wire logic i_func_echo,
  input wire logic i_func_echo_n,
  input wire logic i_func_term_en,
  input wire logic [Q_W-1:0] o_q,
  input wire logic o_q_oe,
  input wire logic o_vld,
  input wire logic o_echo,
  input wire logic o_echo_n,
  input wire logic o_term_en
);
  // ----------------------------------------------------------------
  // Link timing and pin control
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Test clock high long enough that no detected falling edge is still in flight
  sequence tck_high_run;
    i_tck [*5];
  endsequence
  // Termination on means neither test mode that disables it is active
  sequence func_mode;
    o_term_en;
  endsequence
  a_tdo_hold_high: assert property (tck_high_run |-> $stable(o_tdo))
    else $error("tdo changed while test clock high");
  a_oe_hold_high: assert property (tck_high_run |-> $stable(o_tdo_oe))
    else $error("tdo enable changed while test clock high");
  a_term_only_func: assert property (o_term_en |-> $past(i_func_term_en))
    else $error("termination on without functional request");
  a_q_follow_func: assert property (func_mode |-> o_q == $past(i_func_q))
    else $error("read data not following functional source");
  a_qoe_follow_func: assert property (func_mode |-> o_q_oe == $past(i_func_q_oe))
    else $error("driver enable not following functional source");
  a_vld_follow_func: assert property (func_mode |-> o_vld == $past(i_func_vld))
    else $error("valid not following functional source");
  a_echo_follow_func: assert property (func_mode |-> o_echo == $past(i_func_echo))
    else $error("echo clock not following functional source");
  a_echon_follow_func: assert property (func_mode |-> o_echo_n == $past(i_func_echo_n))
    else $error("inverted echo clock not following functional source");
endmodule

bind scan_dr_top scan_dr_checker #(.Q_W(Q_W)) scan_dr_checker_inst (.i_clk(i_clk), .i_rst(i_rst), .i_tck(i_tck),
  .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_func_q(i_func_q), .i_func_q_oe(i_func_q_oe), .i_func_vld(i_func_vld),
  .i_func_echo(i_func_echo), .i_func_echo_n(i_func_echo_n), .i_func_term_en(i_func_term_en), .o_q(o_q),
  .o_q_oe(o_q_oe), .o_vld(o_vld), .o_echo(o_echo), .o_echo_n(o_echo_n), .o_term_en(o_term_en));

// File: tb/jtag_host_model.sv
// Behavioural external test controller driving the serial scan link
`timescale 1ns/1ps
module jtag_host_model (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  // Clock rests low between steps; it only runs while a step is in progress
  initial
  begin
    o_tck = 1'h0;
    o_tms = 1'h1;
    o_tdi = 1'h0;
  end
  // One 125 ns period: mode and data change on the fall, data out is taken just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #62.5;
    tdo = i_tdo;
    o_tck = 1'h1;
    #62.5;
    o_tck = 1'h0;
  endtask
endmodule

// File: tb/scan_dr_top_tb_top.sv
// Self-checking bench for the boundary-scan data registers
`timescale 1ns/1ps
`include "scan_params.svh"
module scan_dr_top_tb_top;
  localparam logic [19:0] DEV = 20'h3C5A9; // Arbitrary value
  localparam logic [10:0] MFR = 11'h5B6; // Arbitrary value
  localparam logic [127:0] NC = 128'h0000_0000_0000_0000_0000_0000_F000_0000;
  localparam logic [127:0] PADS = 128'hA5A5_5A5A_C3C3_3C3C_0FF0_F00F_1234_5678;
  logic i_clk, i_rst, tck, tms, tdi, tdo, tdo_oe, oe, q_oe, vld, echo, echo_n, term_en;
  logic f_oe, f_vld, f_echo, f_echo_n, f_term;
  logic [35:0] f_q, q;
  logic [128:0] dout;
  logic [39:0] held, prev;
  logic [2:0] byp [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
  logic [2:0] smp [2] = '{`IR_SAMPLE, `IR_SAMPLE_HIZ};
  logic [128:0] ext [2] = '{{1'h1, 89'h0, 39'h5A_F0F0_A5C3}, {1'h0, 89'h0, 39'h25_0F0F_5A3C}};
  int n_errors, cmp_count, cyc;

  jtag_host_model jtag_host_model_inst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
  scan_dr_top #(.DEV_ID(DEV), .MFR_ID(MFR), .NC_MASK(NC)) scan_dr_top_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_ce(1'h1), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pad_level(PADS),
    .i_func_q(f_q), .i_func_q_oe(f_oe), .i_func_vld(f_vld), .i_func_echo(f_echo), .i_func_echo_n(f_echo_n),
    .i_func_term_en(f_term), .o_q(q), .o_q_oe(q_oe), .o_vld(vld), .o_echo(echo), .o_echo_n(echo_n),
    .o_term_en(term_en));

  // ----------------------------------------------------------------
  // Clock, functional traffic and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  // Functional sources other than the termination request keep moving so pin-following faults cannot hide
  always @(posedge i_clk)
  begin
    f_q <= f_q + 36'h1;
    f_vld <= ~f_vld;
    f_echo <= f_q[1];
    f_echo_n <= ~f_q[1];
    f_oe <= f_q[2];
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [128:0] seen, input logic [128:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One link step with data in held low
  task automatic go(input logic m);
    logic d;
    jtag_host_model_inst.step(m, 1'h0, d);
  endtask

  // Instruction load from idle, checking the fixed capture pattern
  task automatic ir(input logic [2:0] code);
    logic [2:0] o;
    go(1'h1);
    go(1'h1);
    go(1'h0);
    go(1'h0);
    for (int i = 0; i < 3; i++) jtag_host_model_inst.step(i == 2, code[i], o[i]);
    go(1'h1);
    go(1'h0);
    chk({126'h0, o}, {126'h0, `IR_CAPTURE_VAL});
  endtask

  // Data scan from idle; pins are snapshotted in Exit1, before the update
  task automatic dr(input int n, input logic [128:0] d);
    go(1'h1);
    go(1'h0);
    go(1'h0);
    dout = '0;
    for (int i = 0; i < n; i++) jtag_host_model_inst.step(i == n - 1, d[i], dout[i]);
    held = {q_oe, echo_n, echo, vld, q};
    oe = tdo_oe;
    go(1'h1);
    go(1'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_rst = 1'h1;
    f_q = 36'h0;
    {f_oe, f_vld, f_echo, f_echo_n, f_term} = 5'h1;
    {n_errors, cmp_count, cyc} = '0;
    prev = 40'h0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'h0;
    repeat (3) @(posedge i_clk);
    go(1'h0);
    // Identification is selected out of reset; bits fed in follow 32 steps later
    dr(64, {97'h0, 32'hC3A5_0F1E});
    chk({65'h0, dout[63:0]}, {65'h0, 32'hC3A5_0F1E, DEV, MFR, `ID_START_VAL});
    // Data out is driven while shifting and released once the scan is back in idle
    chk({127'h0, oe, tdo_oe}, {127'h0, 2'h2});
    foreach (byp[k])
    begin
      ir(byp[k]);
      dr(2, 129'h3);
      chk({127'h0, dout[1:0]}, {127'h0, 2'h2});
    end
    // Five steps with mode high return to identification
    repeat (5) go(1'h1);
    go(1'h0);
    dr(32, '0);
    chk({97'h0, dout[31:0]}, {97'h0, DEV, MFR, `ID_START_VAL});
    chk({128'h0, term_en}, {128'h0, 1'h1});
    foreach (smp[k])
    begin
      ir(smp[k]);
      dr(129, '0);
      chk(dout, {`DRV_EN_CAPTURE, PADS & ~NC});
      chk({128'h0, term_en}, {128'h0, smp[k] == `IR_SAMPLE});
      chk({128'h0, q_oe & (smp[k] == `IR_SAMPLE_HIZ)}, '0);
    end
    ir(`IR_EXTEST);
    chk({128'h0, term_en}, '0);
    // Driver enable set, then cleared, to see the data drivers gated both ways
    foreach (ext[k])
    begin
      dr(129, ext[k]);
      chk({89'h0, held}, {89'h0, prev});
      go(1'h0);
      prev = {ext[k][128], ext[k][38:0]};
      chk({89'h0, q_oe, echo_n, echo, vld, q}, {89'h0, prev});
    end
    close_out();
  end
endmodule
